// File: core/hpc_cfg.svh
`ifndef HPC_CFG_SVH
`define HPC_CFG_SVH

// Register offsets, as printed
`define HPC_OFS_PIN_CFG      8'hA4
`define HPC_OFS_SETUP_ONE    8'hA6
`define HPC_PIN_CFG_RESET    32'h0000_0000

// Pin behaviour register fields
`define HPC_RATE_SRC_LSB     0
`define HPC_STOP_OVR_LSB     2
`define HPC_ANGLE_SEL_BIT    4
`define HPC_STOP_MODE_BIT    5

// Setup register fields
`define HPC_SUPPLY_LSB       0
`define HPC_TARGET_LSB       20
`define HPC_SENSE_LSB        28
`define HPC_SUPPLY_BAD       2'h3

`define HPC_ANGLE_W          16

`endif

// File: core/hpc_pkg.sv
package hpc_pkg;
   `include "hpc_cfg.svh"

   typedef enum logic [1:0] {
      HPC_RATE_ANALOG,
      HPC_RATE_DUTY,
      HPC_RATE_REGISTER,
      HPC_RATE_FREQ
   } hpc_rate_t;

   typedef enum logic [1:0] {
      HPC_SUPPLY_15V,
      HPC_SUPPLY_30V,
      HPC_SUPPLY_60V,
      HPC_SUPPLY_UNDEF
   } hpc_supply_t;

   // Register access from the serial-bus engine
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } hpc_req_t;

   // Decoded stop state toward the motor control
   typedef struct packed {
      logic                    lowSide;
      logic                    align;
      logic [`HPC_ANGLE_W-1:0] angle;
   } hpc_stop_t;
endpackage

// File: core/hpc_regs.sv
// Function
// - Stop mode bit: 0 low-side, 1 align
// - Align angle: held last angle or configured
// - Override: 0/3 pin, 1 force, 2 none
// - Rate source: analog, duty, register, frequency
// - Sense route: none, phase A, B, C
// - Supply scaling 15/30/60 V, code 3 unused
`timescale 1ns/100ps
`include "hpc_cfg.svh"
module hpc_regs (
   input  wire logic                    sys_clk,
   input  wire logic                    reset,
   input  wire hpc_pkg::hpc_req_t       req,
   output logic [31:0]                  rdData_r,
   output logic                         rdValid_r,
   input  wire logic [31:0]             nvSetup,
   input  wire logic                    stopPin,
   input  wire logic [`HPC_ANGLE_W-1:0] lastAngle,
   input  wire logic [`HPC_ANGLE_W-1:0] alignAngleCfg,
   output hpc_pkg::hpc_stop_t           stop_r,
   output hpc_pkg::hpc_rate_t           rateSrc_r,
   output logic [2:0]                   senseRoute_r,
   output hpc_pkg::hpc_supply_t         supplyScale_r,
   output logic [6:0]                   targetAddr_r,
   output logic                         nvLoaded_r
);
   import hpc_pkg::*;

   logic [31:0]             pinCfg_r;
   logic [31:0]             setup_r;
   logic                    pinS1_r;
   logic                    pinS2_r;
   logic                    pinS3_r;
   logic                    pinLvl_r;
   logic                    stopReq_nxt;
   logic                    stopReq_r;
   logic [`HPC_ANGLE_W-1:0] heldAngle_r;
   logic [1:0]              ovr;
   logic [1:0]              wrSupply;
   logic                    wrPin;
   logic                    wrSetup;

   assign wrPin   = req.wr && req.addr == `HPC_OFS_PIN_CFG;
   assign wrSetup = req.wr && req.addr == `HPC_OFS_SETUP_ONE;
   assign ovr     = pinCfg_r[`HPC_STOP_OVR_LSB +: 2];
   assign wrSupply = req.wdata[`HPC_SUPPLY_LSB +: 2];

   // All bits, reserved ones too, are stored so read-back is faithful
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pinCfg_r <= `HPC_PIN_CFG_RESET;
      end else if (wrPin) begin
         pinCfg_r <= req.wdata;
      end
   end

   // Nonvolatile image is taken on the first edge after release, so the
   // async reset itself only loads a constant
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         setup_r    <= 32'h0000_0000;
         nvLoaded_r <= 1'b0;
      end else if (!nvLoaded_r) begin
         setup_r    <= nvSetup;
         nvLoaded_r <= 1'b1;
      end else if (wrSetup) begin
         setup_r <= req.wdata;
         // Undefined scaling code is refused: the old setting overrides
         // the written one, while the rest of the word still lands
         if (wrSupply == `HPC_SUPPLY_BAD) begin
            setup_r[`HPC_SUPPLY_LSB +: 2] <=
               setup_r[`HPC_SUPPLY_LSB +: 2];
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rdData_r  <= 32'h0000_0000;
         rdValid_r <= 1'b0;
      end else begin
         rdValid_r <= req.rd;
         unique case (req.addr)
            `HPC_OFS_PIN_CFG:   rdData_r <= pinCfg_r;
            `HPC_OFS_SETUP_ONE: rdData_r <= setup_r;
            default:            rdData_r <= 32'h0000_0000;
         endcase
      end
   end

   // Three-stage synchroniser; a level counts once stages two and three agree
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pinS1_r  <= 1'b0;
         pinS2_r  <= 1'b0;
         pinS3_r  <= 1'b0;
         pinLvl_r <= 1'b0;
      end else begin
         pinS1_r <= stopPin;
         pinS2_r <= pinS1_r;
         pinS3_r <= pinS2_r;
         if (pinS2_r == pinS3_r) begin
            pinLvl_r <= pinS3_r;
         end
      end
   end

   always_comb begin
      unique case (ovr)
         2'h1:    stopReq_nxt = 1'b1;
         2'h2:    stopReq_nxt = 1'b0;
         default: stopReq_nxt = pinLvl_r;
      endcase
   end

   // Angle is frozen on the edge the stop begins
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         stopReq_r   <= 1'b0;
         heldAngle_r <= '0;
      end else begin
         stopReq_r <= stopReq_nxt;
         if (stopReq_nxt && !stopReq_r) begin
            heldAngle_r <= lastAngle;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         stop_r <= '0;
      end else begin
         stop_r.lowSide <= stopReq_r && !pinCfg_r[`HPC_STOP_MODE_BIT];
         stop_r.align   <= stopReq_r && pinCfg_r[`HPC_STOP_MODE_BIT];
         stop_r.angle   <= pinCfg_r[`HPC_ANGLE_SEL_BIT] ? alignAngleCfg
                                                       : heldAngle_r;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rateSrc_r     <= HPC_RATE_ANALOG;
         senseRoute_r  <= 3'h0;
         supplyScale_r <= HPC_SUPPLY_15V;
         targetAddr_r  <= 7'h00;
      end else begin
         rateSrc_r <= hpc_rate_t'(pinCfg_r[`HPC_RATE_SRC_LSB +: 2]);
         unique case (setup_r[`HPC_SENSE_LSB +: 2])
            2'h0: senseRoute_r <= 3'h0;
            2'h1: senseRoute_r <= 3'h1;
            2'h2: senseRoute_r <= 3'h2;
            2'h3: senseRoute_r <= 3'h4;
         endcase
         supplyScale_r <= hpc_supply_t'(setup_r[`HPC_SUPPLY_LSB +: 2]);
         targetAddr_r  <= setup_r[`HPC_TARGET_LSB +: 7];
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   a_stop_low_side: assert property (
      nvLoaded_r && ovr == 2'h1 && !pinCfg_r[`HPC_STOP_MODE_BIT]
      ##1 $stable(pinCfg_r) |=> stop_r.lowSide && !stop_r.align)
      else $error("forced low-side stop not shown");
   a_stop_align: assert property (
      ovr == 2'h1 && pinCfg_r[`HPC_STOP_MODE_BIT] ##1 $stable(pinCfg_r)
      |=> stop_r.align && !stop_r.lowSide)
      else $error("forced align stop not shown");
   a_angle_held: assert property (
      stopReq_nxt && !stopReq_r ##1 !pinCfg_r[`HPC_ANGLE_SEL_BIT]
      |=> stop_r.angle == $past(lastAngle, 2))
      else $error("held angle not used");
   a_angle_cfg: assert property (
      pinCfg_r[`HPC_ANGLE_SEL_BIT] |=> stop_r.angle == $past(alignAngleCfg))
      else $error("configured angle not used");
   a_no_stop_ovr: assert property (
      ovr == 2'h2 ##1 ovr == 2'h2 |=> !stop_r.lowSide && !stop_r.align)
      else $error("stop seen while overridden off");
   // Override and pin level must hold together over the whole window,
   // otherwise a legal override change in between would trip the check
   a_pin_follow: assert property (
      ((ovr == 2'h0 || ovr == 2'h3) && pinLvl_r) [*3]
      |=> stop_r.lowSide || stop_r.align)
      else $error("stop pin not followed");
   a_pin_idle: assert property (
      ((ovr == 2'h0 || ovr == 2'h3) && !pinLvl_r) [*3]
      |=> !stop_r.lowSide && !stop_r.align)
      else $error("stop seen with pin released");
   a_held_frozen: assert property (
      stopReq_r && $past(stopReq_r) |-> $stable(heldAngle_r))
      else $error("held angle moved during stop");
   a_rate_src: assert property (
      wrPin |=> ##1 rateSrc_r ==
         hpc_rate_t'($past(req.wdata[`HPC_RATE_SRC_LSB +: 2], 2)))
      else $error("rate source wrong");
   a_sense_onehot: assert property (
      $countones(senseRoute_r) <= 1 &&
      (senseRoute_r == 3'h0) ==
      ($past(setup_r[`HPC_SENSE_LSB +: 2]) == 2'h0))
      else $error("sense route wrong");
   a_sense_phase_c: assert property (
      setup_r[`HPC_SENSE_LSB +: 2] == 2'h3 |=> senseRoute_r == 3'h4)
      else $error("phase C sense not routed");
   a_supply_legal: assert property (
      nvLoaded_r && $past(nvLoaded_r) && wrSetup
      && wrSupply == `HPC_SUPPLY_BAD
      |=> $stable(setup_r[`HPC_SUPPLY_LSB +: 2]))
      else $error("undefined supply code taken");
   a_supply_follow: assert property (
      nvLoaded_r |=> supplyScale_r ==
         hpc_supply_t'($past(setup_r[`HPC_SUPPLY_LSB +: 2])))
      else $error("supply scaling not shown");
   a_target_addr: assert property (
      $rose(nvLoaded_r) |=> targetAddr_r ==
         $past(setup_r[`HPC_TARGET_LSB +: 7]))
      else $error("target address not from stored image");
   a_rd_setup: assert property (
      req.rd && req.addr == `HPC_OFS_SETUP_ONE
      |=> rdValid_r && rdData_r == $past(setup_r))
      else $error("setup read-back wrong");
   a_rd_quiet: assert property (
      !req.rd |=> !rdValid_r)
      else $error("read valid without request");

   c_force_stop:  cover property (ovr == 2'h1 ##2 stop_r.align);
   c_phase_c:     cover property (senseRoute_r == 3'h4);
   c_pin_stop:    cover property ($rose(pinLvl_r) ##2 stop_r.lowSide);
   c_bad_supply:  cover property (wrSetup && wrSupply == `HPC_SUPPLY_BAD);
   c_read_setup:  cover property (req.rd && req.addr == `HPC_OFS_SETUP_ONE);
endmodule

// File: dv/tb_top.sv
`timescale 1ns/100ps
`include "hpc_cfg.svh"
module tb_top;
   import hpc_pkg::*;
   // Pattern: sense phase B, target 7'h55, 30 V scaling
   localparam logic [31:0] NV = 32'h2550_0001;
   logic               sys_clk, reset, stopPin, rdValid_r, nvLoaded_r;
   hpc_req_t           req;
   logic [31:0]        rdData_r, d;
   logic [15:0]        lastAngle, alignAngleCfg;
   hpc_stop_t          stop_r;
   hpc_rate_t          rateSrc_r;
   hpc_supply_t        supplyScale_r;
   logic [2:0]         senseRoute_r;
   logic [6:0]         targetAddr_r;
   int                 err_count, samples_checked;
   hpc_regs dut (.sys_clk(sys_clk), .reset(reset), .req(req),
      .rdData_r(rdData_r), .rdValid_r(rdValid_r), .nvSetup(NV),
      .stopPin(stopPin), .lastAngle(lastAngle),
      .alignAngleCfg(alignAngleCfg), .stop_r(stop_r),
      .rateSrc_r(rateSrc_r), .senseRoute_r(senseRoute_r),
      .supplyScale_r(supplyScale_r), .targetAddr_r(targetAddr_r),
      .nvLoaded_r(nvLoaded_r));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Decoded outputs settle one edge after the write edge, stop outputs two
   task wr(input logic [7:0] a, input logic [31:0] v);
      req.addr = a;
      req.wdata = v;
      req.wr = 1'b1;
      @(posedge sys_clk) #1;
      req.wr = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] v);
      int n;
      req.addr = a;
      req.rd = 1'b1;
      @(posedge sys_clk) #1;
      req.rd = 1'b0;
      for (n = 0; n < 4 && rdValid_r !== 1'b1; n++) @(posedge sys_clk) #1;
      if (n == 4) begin
         err_count++;
         stop_test;
      end
      v = rdData_r;
      @(posedge sys_clk) #1;
   endtask
   task t_reset;
      chk(nvLoaded_r, 1);
      chk(targetAddr_r, 7'h55);
      chk(senseRoute_r, 3'h2);
      chk(supplyScale_r, HPC_SUPPLY_30V);
      rd(8'hA4, d);
      chk(d, 32'h0000_0000);
      rd(8'hA6, d);
      chk(d, NV);
      rd(8'hA5, d);
      chk(d, 32'h0000_0000);
      $display("reset test done");
   endtask
   task t_rate;
      for (int i = 0; i < 4; i++) begin
         wr(8'hA4, i);
         chk(rateSrc_r, i);
      end
      $display("rate test done");
   endtask
   task t_sense;
      for (int i = 0; i < 4; i++) begin
         wr(8'hA6, {2'h0, 2'(i), 1'b0, 7'(i + 16), 18'h0, 2'h2});
         chk(senseRoute_r, i == 0 ? 0 : 1 << (i - 1));
         chk(targetAddr_r, 7'(i + 16));
         chk(supplyScale_r, HPC_SUPPLY_60V);
      end
      $display("sense test done");
   endtask
   task t_supply;
      wr(8'hA6, 32'h0000_0000);
      chk(supplyScale_r, HPC_SUPPLY_15V);
      wr(8'hA6, 32'h0000_0001);
      chk(supplyScale_r, HPC_SUPPLY_30V);
      // Undefined scaling code must not take effect, the rest still lands
      wr(8'hA6, 32'h0010_0003);
      chk(supplyScale_r, HPC_SUPPLY_30V);
      chk(targetAddr_r, 7'h01);
      rd(8'hA6, d);
      chk(d[1:0], 2'h1);
      $display("supply test done");
   endtask
   task stp(input logic [31:0] c, input logic p, input logic ls,
            input logic al, input logic [15:0] ang);
      wr(8'hA4, c);
      stopPin = p;
      repeat (8) @(posedge sys_clk);
      #1;
      // Moving angle after the stop began must not disturb it
      lastAngle = 16'h5555;
      repeat (2) @(posedge sys_clk);
      #1;
      chk({stop_r.lowSide, stop_r.align}, {ls, al});
      if (al)
         chk(stop_r.angle, ang);
      stopPin = 1'b0;
      lastAngle = 16'h1234;
      wr(8'hA4, 32'h0000_0000);
      repeat (8) @(posedge sys_clk);
      #1;
      chk({stop_r.lowSide, stop_r.align}, 2'h0);
   endtask
   task t_stop;
      stp(32'h0000_0008, 1'b1, 1'b0, 1'b0, 16'h0000);
      stp(32'h0000_0004, 1'b0, 1'b1, 1'b0, 16'h0000);
      stp(32'h0000_0020, 1'b1, 1'b0, 1'b1, 16'h1234);
      stp(32'h0000_003C, 1'b1, 1'b0, 1'b1, 16'h0ABC);
      stp(32'h0000_0000, 1'b1, 1'b1, 1'b0, 16'h0000);
      stp(32'h0000_0024, 1'b0, 1'b0, 1'b1, 16'h1234);
      stp(32'h0000_0000, 1'b0, 1'b0, 1'b0, 16'h0000);
      $display("stop test done");
   endtask
   // Mid-run reset clears the pin register and reloads the stored image
   task t_rerun;
      wr(8'hA4, 32'h0000_0003);
      reset = 1'b1;
      @(posedge sys_clk) #1;
      chk(nvLoaded_r, 0);
      chk(rateSrc_r, HPC_RATE_ANALOG);
      chk(targetAddr_r, 7'h00);
      reset = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      chk(nvLoaded_r, 1);
      chk(targetAddr_r, 7'h55);
      chk(supplyScale_r, HPC_SUPPLY_30V);
      rd(8'hA4, d);
      chk(d, 32'h0000_0000);
      $display("reset rerun test done");
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      reset = 1'b1;
      stopPin = 1'b0;
      req = '0;
      lastAngle = 16'h1234;
      alignAngleCfg = 16'h0ABC;
      err_count = 0;
      samples_checked = 0;
      repeat (6) @(posedge sys_clk);
      #1;
      reset = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      t_reset;
      t_rate;
      t_sense;
      t_supply;
      t_stop;
      t_rerun;
      stop_test;
   end
endmodule
